// ==== hdl/can_boot_pkg.sv ====
// Constants shared by the CAN boot loader block
package can_boot_pkg;
  // Avalon register byte offsets
  localparam logic [4:0]  REG_STATUS     = 5'h00;
  localparam logic [4:0]  REG_MEASURE    = 5'h04;
  localparam logic [4:0]  REG_TIMING     = 5'h08;
  localparam logic [4:0]  REG_CHIP_ID    = 5'h0C;
  localparam int          ADDR_W         = 5;
  // Load sequence
  localparam int          LOAD_BYTES     = 128;
  localparam logic [15:0] RAM_FIRST      = 16'hFA40;
  localparam logic [15:0] RAM_LAST       = 16'hFABF;
  // Redirected fetch window
  localparam logic [23:0] FLASH_LO       = 24'h010000;
  localparam logic [23:0] FLASH_HI       = 24'h08FFFF;
  // Measurement and timing derivation
  localparam int          STOP_EDGES     = 5;
  localparam int          BRP_DIVISOR    = 1451;
  localparam int          FRAME_FACTOR   = 58;
  localparam int          TQ_MIN         = 8;
  localparam int          TQ_MAX         = 25;
  localparam logic [1:0]  SJW_TQ         = 2'h2;
  // Message objects
  localparam logic [10:0] ACK_ID         = 11'h0E6;
  localparam logic [3:0]  ACK_DLC        = 4'h3;
  localparam logic [10:0] RX_ID          = 11'h005;
  // Arbitrary identity values
  localparam logic [7:0]  ACK_CODE_RST   = 8'hA5;
  localparam logic [15:0] CHIP_ID_RST    = 16'h1234;
  // Field positions in the timing register
  localparam int          TIM_BRP_LSB    = 0;
  localparam int          TIM_SJW_LSB    = 8;
  localparam int          TIM_SEG1_LSB   = 16;
  localparam int          TIM_SEG2_LSB   = 24;
endpackage

// ==== hdl/can_boot_loader.sv ====
// CAN boot loader: bit-rate measurement, object setup and 128-byte load
//
// Functional notes
// - After setup the block collects exactly 128 data bytes from CAN.
// - Bytes go in arrival order to RAM addresses FA40 through FABF.
// - After the last byte, execution starts at FA40; loader mode stays on.
// - In loader mode code fetches from 01_0000..08_FFFF go to test flash.
// - While loader mode lasts, watchdog stays off and flash stays restricted.
// - Poll UART and CAN receive lines; a low CAN level starts the timer, a low UART level selects UART boot.
// - Timer runs from first dominant edge to fifth recessive stuff bit.
// - Timer counts every clock; start and stop latency stays under 6.
// - Count equals 58 times prescaler-plus-one times quanta per bit.
// - Bit time holds 8 to 25 quanta, smallest prescaler preferred.
// - Prescaler field is the count divided by 1451, truncated.
// - Quanta per bit is count over scaled divisor, rounded past half.
// - Segment fields come from a table, sample point at 70 to 80 percent.
// - Jump width is always 2 quanta.
// - After setup the transmit pin drives recessive as an output.
// - Ack object: identifier E6h, length 3, ack code, chip id low, high.
// - Receive object takes identifier 5h only; one data byte per message.
// - No message other than the acknowledge is sent while loading.
// - Ack is sent only when a remote frame asks for it.
// - Loader mode is entered when boot select is low at reset release.
`timescale 1ns/1ps
`default_nettype none
module can_boot_loader #(
  parameter int TIMER_W = 16
) (
  input  wire logic                            sys_clk,
  input  wire logic                            rst,
  // Straps and receive lines
  input  wire logic                            boot_select_pin,
  input  wire logic                            uart_receive_line,
  input  wire logic                            can_receive_pin,
  output logic                                 can_transmit_pin,
  output logic                                 can_transmit_oe,
  // Messages delivered by the CAN controller
  input  wire logic                            rx_valid,
  input  wire logic [10:0]                     rx_id,
  input  wire logic                            rx_remote,
  input  wire logic [7:0]                      rx_data0,
  // Acknowledge transmission request
  output logic                                 tx_request,
  output logic [10:0]                          tx_id,
  output logic [3:0]                           tx_dlc,
  output logic [23:0]                          tx_data,
  // Derived bit timing
  output logic [5:0]                           prescaler_field,
  output logic [4:0]                           segment_before_sample,
  output logic [4:0]                           segment_after_sample,
  output logic [1:0]                           sjw_field,
  output logic                                 can_enabled,
  // Internal RAM write port
  output logic                                 ram_we,
  output logic [15:0]                          ram_addr,
  output logic [7:0]                           ram_wdata,
  // Execution and memory control
  output logic                                 boot_loader_mode,
  output logic                                 uart_boot_selected,
  output logic                                 exec_start,
  output logic [15:0]                          exec_address,
  output logic                                 watchdog_disable,
  output logic                                 flash_restricted,
  input  wire logic                            fetch_valid,
  input  wire logic                            fetch_is_code,
  input  wire logic [23:0]                     fetch_addr,
  output logic                                 fetch_redirect,
  // Avalon-MM slave
  input  wire logic [can_boot_pkg::ADDR_W-1:0] avs_address,
  input  wire logic                            avs_read,
  input  wire logic                            avs_write,
  input  wire logic [31:0]                     avs_writedata,
  output logic [31:0]                          avs_readdata,
  output logic                                 avs_waitrequest
);
  import can_boot_pkg::*;

  // Wider counters would overflow the six-bit prescaler field at slow host
  // rates; narrower ones leave too little range for a whole frame
  if (TIMER_W < 12 || TIMER_W > 16) begin : g_timer_width
    $error("TIMER_W must lie between 12 and 16");
  end

  // Sequencer states. STRAP lets one edge pass after reset so the strap is
  // read from a settled pin; NORMAL, RUN and UART are parking states that
  // only a new reset leaves.
  typedef enum logic [3:0] {
    ST_STRAP, ST_NORMAL, ST_POLL, ST_MEASURE, ST_DIV_BRP, ST_DIV_TQ,
    ST_SETUP, ST_LOAD, ST_RUN, ST_UART
  } state_e;

  // Segment table: after-sample segment is ceil(20 percent), rest goes before
  // Quanta are clamped to 8..25 first, so a mismeasured frame still gives a
  // legal pair of segments.
  function automatic logic [4:0] seg_after(input logic [4:0] tq);
    seg_after = 5'((32'(tq) * 2 + 9) / 10);
  endfunction

  state_e               state_q, state_d;
  logic                 strap_done_q;
  logic [TIMER_W-1:0]   count_q;
  logic [2:0]           edges_q;
  logic                 rx_prev_q;
  logic [TIMER_W-1:0]   rem_q;
  logic [TIMER_W-1:0]   divisor_q;
  logic [5:0]           quot_q;
  logic [7:0]           nbytes_q;
  logic [15:0]          chip_id_q;

  // Output flops
  logic                 tx_pin_q, tx_oe_q, tx_req_q, can_en_q;
  logic [5:0]           brp_q;
  logic [4:0]           seg1_q, seg2_q;
  logic                 ram_we_q;
  logic [15:0]          ram_addr_q;
  logic [7:0]           ram_wdata_q;
  logic                 mode_q, uart_q, exec_q, redirect_q;
  logic [31:0]          rdata_q;
  logic                 wait_q;

  // Decodes
  // The previous-level flop resets high, so an idle recessive line cannot
  // fake a rising edge in the first measuring cycle.
  wire                  rec_edge     = can_receive_pin && !rx_prev_q;
  wire                  last_edge    = rec_edge && (edges_q == 3'(STOP_EDGES - 1));
  wire                  overflow     = &count_q;
  wire                  brp_step     = rem_q >= TIMER_W'(BRP_DIVISOR);
  wire                  tq_step      = rem_q >= divisor_q;
  wire [TIMER_W:0]      rem_twice    = {rem_q, 1'b0};
  wire                  round_up     = rem_twice > {1'b0, divisor_q};
  wire [5:0]            tq_round     = quot_q + {5'h00, round_up};
  wire [4:0]            tq_clamped   = (tq_round < 6'(TQ_MIN)) ? 5'(TQ_MIN) :
                                       (tq_round > 6'(TQ_MAX)) ? 5'(TQ_MAX) : tq_round[4:0];
  wire [4:0]            seg2_new     = seg_after(tq_clamped);
  wire [4:0]            seg1_new     = tq_clamped - seg2_new - 5'h01;
  wire [TIMER_W-1:0]    div_new      = TIMER_W'(FRAME_FACTOR * (32'(quot_q) + 1));
  wire                  rx_accept    = rx_valid && !rx_remote && rx_id == RX_ID;
  wire                  ack_asked    = rx_valid && rx_remote && rx_id == ACK_ID;
  wire                  load_done    = rx_accept && nbytes_q == 8'(LOAD_BYTES - 1);
  wire                  in_flash     = fetch_addr >= FLASH_LO && fetch_addr <= FLASH_HI;
  wire                  bus_take     = (avs_read || avs_write) && !wait_q;
  wire                  id_write     = bus_take && avs_write && avs_address == REG_CHIP_ID;
  wire [31:0]           status_word  = {16'h0000, nbytes_q, 4'h0, 4'(state_q)};
  wire [31:0]           timing_word  = (32'(brp_q) << TIM_BRP_LSB) |
                                       (32'(SJW_TQ) << TIM_SJW_LSB) |
                                       (32'(seg1_q) << TIM_SEG1_LSB) |
                                       (32'(seg2_q) << TIM_SEG2_LSB);
  wire [31:0]           read_word    = (avs_address == REG_STATUS)  ? status_word :
                                       (avs_address == REG_MEASURE) ? 32'(count_q) :
                                       (avs_address == REG_TIMING)  ? timing_word :
                                       (avs_address == REG_CHIP_ID) ? {16'h0000, chip_id_q} :
                                       32'h0000_0000;

  // Sequencer next state
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_STRAP:   if (strap_done_q) state_d = boot_select_pin ? ST_NORMAL : ST_POLL;
      ST_NORMAL:  state_d = ST_NORMAL;
      ST_POLL: begin
        if (!can_receive_pin) begin
          state_d = ST_MEASURE;
        end else if (!uart_receive_line) begin
          state_d = ST_UART;
        end
      end
      ST_MEASURE: begin
        if (overflow) begin
          state_d = ST_POLL;
        end else if (last_edge) begin
          state_d = ST_DIV_BRP;
        end
      end
      ST_DIV_BRP: if (!brp_step) state_d = ST_DIV_TQ;
      ST_DIV_TQ:  if (!tq_step) state_d = ST_SETUP;
      ST_SETUP:   state_d = ST_LOAD;
      ST_LOAD:    if (load_done) state_d = ST_RUN;
      ST_RUN:     state_d = ST_RUN;
      ST_UART:    state_d = ST_UART;
    endcase
  end

  // Strap capture one edge after reset release
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_q      <= ST_STRAP;
      strap_done_q <= 1'b0;
      rx_prev_q    <= 1'b1;
    end else begin
      state_q      <= state_d;
      strap_done_q <= 1'b1;
      rx_prev_q    <= can_receive_pin;
    end
  end

  // Measuring timer and recessive edge counter
  // An all-ones count means the host is too slow for the counter; the
  // sequencer then drops back to polling instead of deriving nonsense.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      count_q <= '0;
      edges_q <= 3'h0;
    end else if (state_q == ST_POLL) begin
      count_q <= '0;
      edges_q <= 3'h0;
    end else if (state_q == ST_MEASURE) begin
      count_q <= count_q + 1'b1;
      edges_q <= edges_q + {2'b00, rec_edge};
    end
  end

  // Prescaler division then quanta division with rounding
  // Both divisions are repeated subtraction, one step per clock; the
  // slowest frame the counter holds needs at most 45 plus 25 steps.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rem_q     <= '0;
      divisor_q <= '0;
      quot_q    <= 6'h00;
      brp_q     <= 6'h00;
      seg1_q    <= 5'h00;
      seg2_q    <= 5'h00;
    end else if (state_q == ST_MEASURE) begin
      rem_q  <= count_q + 1'b1;
      quot_q <= 6'h00;
    end else if (state_q == ST_DIV_BRP) begin
      if (brp_step) begin
        rem_q  <= rem_q - TIMER_W'(BRP_DIVISOR);
        quot_q <= quot_q + 6'h01;
      end else begin
        brp_q     <= quot_q;
        divisor_q <= div_new;
        rem_q     <= count_q;
        quot_q    <= 6'h00;
      end
    end else if (state_q == ST_DIV_TQ) begin
      if (tq_step) begin
        rem_q  <= rem_q - divisor_q;
        quot_q <= quot_q + 6'h01;
      end else begin
        seg1_q <= seg1_new;
        seg2_q <= seg2_new;
      end
    end
  end

  // Pin, acknowledge object and receive loop
  // Only the first data byte of an accepted message is kept; other
  // identifiers and messages outside the load phase leave the count alone.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tx_pin_q    <= 1'b1;
      tx_oe_q     <= 1'b0;
      can_en_q    <= 1'b0;
      tx_req_q    <= 1'b0;
      ram_we_q    <= 1'b0;
      ram_addr_q  <= RAM_FIRST;
      ram_wdata_q <= 8'h00;
      nbytes_q    <= 8'h00;
    end else begin
      tx_req_q <= (state_q == ST_LOAD) && ack_asked;
      ram_we_q <= (state_q == ST_LOAD) && rx_accept;
      if (state_q == ST_SETUP) begin
        tx_pin_q <= 1'b1;
        tx_oe_q  <= 1'b1;
        can_en_q <= 1'b1;
      end
      if (state_q == ST_LOAD && rx_accept) begin
        ram_addr_q  <= RAM_FIRST + 16'(nbytes_q);
        ram_wdata_q <= rx_data0;
        nbytes_q    <= nbytes_q + 8'h01;
      end
    end
  end

  // Mode, watchdog, flash restriction and fetch redirection
  // The mode flag is sticky until the next hardware reset; the watchdog
  // and flash restriction outputs follow it directly.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mode_q     <= 1'b0;
      uart_q     <= 1'b0;
      exec_q     <= 1'b0;
      redirect_q <= 1'b0;
    end else begin
      if (state_q == ST_STRAP && strap_done_q && !boot_select_pin) begin
        mode_q <= 1'b1;
      end
      if (state_q == ST_UART) begin
        uart_q <= 1'b1;
      end
      if (state_q == ST_LOAD && load_done) begin
        exec_q <= 1'b1;
      end
      redirect_q <= mode_q && fetch_valid && fetch_is_code && in_flash;
    end
  end

  // Avalon slave: one wait cycle, then answer
  // A request is seen while waitrequest is high and answered one cycle
  // later; write data land at the edge where waitrequest is low.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wait_q    <= 1'b1;
      rdata_q   <= 32'h0000_0000;
      chip_id_q <= CHIP_ID_RST;
    end else begin
      wait_q  <= !((avs_read || avs_write) && wait_q);
      rdata_q <= (avs_read && wait_q) ? read_word : rdata_q;
      if (id_write) begin
        chip_id_q <= avs_writedata[15:0];
      end
    end
  end

  // Constant object fields and timing bits come straight from the package
  assign can_transmit_pin      = tx_pin_q;
  assign can_transmit_oe       = tx_oe_q;
  assign tx_request            = tx_req_q;
  assign tx_id                 = ACK_ID;
  assign tx_dlc                = ACK_DLC;
  assign tx_data               = {chip_id_q[15:8], chip_id_q[7:0], ACK_CODE_RST};
  assign prescaler_field       = brp_q;
  assign segment_before_sample = seg1_q;
  assign segment_after_sample  = seg2_q;
  assign sjw_field             = SJW_TQ;
  assign can_enabled           = can_en_q;
  assign ram_we                = ram_we_q;
  assign ram_addr              = ram_addr_q;
  assign ram_wdata             = ram_wdata_q;
  assign boot_loader_mode      = mode_q;
  assign uart_boot_selected    = uart_q;
  assign exec_start            = exec_q;
  assign exec_address          = RAM_FIRST;
  assign watchdog_disable      = mode_q;
  assign flash_restricted      = mode_q;
  assign fetch_redirect        = redirect_q;
  assign avs_readdata          = rdata_q;
  assign avs_waitrequest       = wait_q;
endmodule // can_boot_loader
`default_nettype wire

// ==== verif/can_boot_loader_chk.sv ====
// Port checker for the CAN boot loader
`timescale 1ns/1ps
`default_nettype none
module can_boot_loader_chk (
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic        can_transmit_pin,
  input wire logic [1:0]  sjw_field,
  input wire logic        rx_valid,
  input wire logic        rx_remote,
  input wire logic [10:0] rx_id,
  input wire logic [7:0]  rx_data0,
  input wire logic        tx_request,
  input wire logic [10:0] tx_id,
  input wire logic [23:0] tx_data,
  input wire logic        ram_we,
  input wire logic [15:0] ram_addr,
  input wire logic [7:0]  ram_wdata,
  input wire logic        boot_loader_mode,
  input wire logic        watchdog_disable,
  input wire logic        flash_restricted,
  input wire logic        exec_start,
  input wire logic        fetch_valid,
  input wire logic        fetch_is_code,
  input wire logic [23:0] fetch_addr,
  input wire logic        fetch_redirect
);
  import can_boot_pkg::*;
  // Code fetch inside the redirected window while loader mode holds
  wire logic in_win = fetch_valid && fetch_is_code && boot_loader_mode
                      && fetch_addr >= FLASH_LO && fetch_addr <= FLASH_HI;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_tx_recessive: assert property (can_transmit_pin)
    else $error("transmit pin not recessive");
  a_sjw_fixed: assert property (sjw_field == SJW_TQ)
    else $error("jump width not 2");
  a_mode_flags: assert property (
    watchdog_disable == boot_loader_mode && flash_restricted == boot_loader_mode)
    else $error("watchdog or flash flag differs from mode");
  a_ram_window: assert property (
    ram_we |-> ram_addr >= RAM_FIRST && ram_addr <= RAM_LAST)
    else $error("ram write outside load area");
  a_ram_cause: assert property (
    ram_we |-> $past(rx_valid) && !$past(rx_remote) && $past(rx_id) == RX_ID
               && ram_wdata == $past(rx_data0))
    else $error("ram write without matching message");
  a_exec_last: assert property ($rose(exec_start) |-> ram_addr == RAM_LAST)
    else $error("start before last byte");
  a_exec_hold: assert property (exec_start |=> exec_start && boot_loader_mode)
    else $error("start or mode dropped");
  a_ack_prompt: assert property (
    tx_request |-> $past(rx_valid) && $past(rx_remote) && $past(rx_id) == ACK_ID)
    else $error("ack sent unprompted");
  a_ack_frame: assert property (
    tx_request |-> tx_id == ACK_ID && tx_data[7:0] == ACK_CODE_RST)
    else $error("ack object contents wrong");
  a_fetch_redir: assert property (in_win |=> fetch_redirect)
    else $error("code fetch not redirected");
  a_fetch_plain: assert property (!in_win |=> !fetch_redirect)
    else $error("fetch redirected wrongly");
  c_byte: cover property (ram_we);
  c_ack: cover property (tx_request);
  c_start: cover property ($rose(exec_start));
endmodule // can_boot_loader_chk
bind can_boot_loader can_boot_loader_chk chk (.*);
`default_nettype wire

// ==== verif/can_host_model.sv ====
// Host programming tool model on the CAN side
`timescale 1ns/1ps
`default_nettype none
module can_host_model (
  input  wire logic        sys_clk,
  output logic             can_receive_pin,
  output logic             rx_valid,
  output logic             rx_remote,
  output logic [10:0]      rx_id,
  output logic [7:0]       rx_data0
);
  // Bus idles recessive through the pull-up
  initial begin
    can_receive_pin = 1'b1;
    rx_valid = 1'b0;
    rx_remote = 1'b0;
    rx_id = 11'h000;
    rx_data0 = 8'h00;
  end
  // Stuffed zero frame, runs alternate dominant and recessive
  task automatic zero_frame(input int bt);
    int lens [14] = '{5, 1, 5, 1, 5, 1, 5, 1, 5, 1, 4, 1, 1, 11};
    @(posedge sys_clk);
    for (int k = 0; k < 14; k++) begin
      can_receive_pin <= k[0];
      repeat (lens[k] * bt) @(posedge sys_clk);
    end
  endtask
  // One delivered message; qualifiers show inverted values once released
  task automatic send_msg(input logic [10:0] id, input logic remote, input logic [7:0] d);
    @(posedge sys_clk);
    rx_valid <= 1'b1;
    rx_id <= id;
    rx_remote <= remote;
    rx_data0 <= d;
    @(posedge sys_clk);
    rx_valid <= 1'b0;
    rx_id <= ~id;
    rx_remote <= ~remote;
    rx_data0 <= ~d;
  endtask
endmodule // can_host_model
`default_nettype wire

// ==== verif/can_boot_loader_test.sv ====
// Self-checking bench for the CAN boot loader
`timescale 1ns/1ps
`default_nettype none
module can_boot_loader_test;
  import can_boot_pkg::*;
  logic        sys_clk = 0, rst = 1, boot_select_pin = 1, uart_receive_line = 1;
  logic        fetch_valid = 0, fetch_is_code = 0, avs_read = 0, avs_write = 0;
  logic [23:0] fetch_addr = 0;
  logic [4:0]  avs_address = 0;
  logic [31:0] avs_writedata = 0, rd;
  wire logic        can_receive_pin, can_transmit_pin, can_transmit_oe, rx_valid, rx_remote;
  wire logic        tx_request, can_enabled, ram_we, boot_loader_mode, uart_boot_selected;
  wire logic        exec_start, watchdog_disable, flash_restricted, fetch_redirect;
  wire logic        avs_waitrequest;
  wire logic [10:0] rx_id, tx_id;
  wire logic [7:0]  rx_data0, ram_wdata;
  wire logic [3:0]  tx_dlc;
  wire logic [23:0] tx_data;
  wire logic [5:0]  prescaler_field;
  wire logic [4:0]  segment_before_sample, segment_after_sample;
  wire logic [1:0]  sjw_field;
  wire logic [15:0] ram_addr, exec_address;
  wire logic [31:0] avs_readdata;
  int          fail_count = 0, n_tests = 0, nbytes, n_ack, p, q, aft, bef, w;
  logic [23:0] fa [5] = '{24'h00FFFF, FLASH_LO, FLASH_HI, 24'h090000, FLASH_LO};
  can_boot_loader DUT (.*);
  can_host_model HOST (.*);
  initial begin
    forever #2.5 sys_clk = ~sys_clk;
  end
  task automatic print_verdict();
    if (fail_count == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One Avalon transfer, held until waitrequest is sampled low
  task automatic av(input logic wr, input logic [4:0] a, input logic [31:0] wd);
    @(posedge sys_clk);
    avs_address <= a;
    avs_read <= !wr;
    avs_write <= wr;
    avs_writedata <= wd;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic boot(input logic sel);
    @(posedge sys_clk);
    rst <= 1'b1;
    boot_select_pin <= sel;
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    nbytes = 0;
    n_ack = 0;
    repeat (3) @(posedge sys_clk);
  endtask
  // Code and data fetches across the window edges
  task automatic fetch_scan(input logic m);
    for (int k = 0; k < 5; k++) begin
      @(posedge sys_clk);
      fetch_valid <= 1'b1;
      fetch_addr <= fa[k];
      fetch_is_code <= (k != 4);
      repeat (2) @(posedge sys_clk);
      chk(32'(fetch_redirect), 32'(m && (k == 1 || k == 2)));
    end
    fetch_valid <= 1'b0;
  endtask
  task automatic run(input int bt);
    boot(1'b0);
    chk(32'({boot_loader_mode, watchdog_disable, flash_restricted}), 7);
    av(0, REG_STATUS, 0);
    chk(32'(rd[3:0]), 2);
    HOST.send_msg(ACK_ID, 1, 0);
    HOST.zero_frame(bt);
    w = 0;
    while (can_transmit_oe !== 1'b1 && w < 3000) begin @(posedge sys_clk); w++; end
    chk(32'({can_transmit_oe, can_transmit_pin, can_enabled}), 7);
    av(0, REG_MEASURE, 0);
    chk(32'(rd + 6 >= 29 * bt && rd <= 29 * bt + 6), 1);
    p = 29 * bt / BRP_DIVISOR;
    q = (29 * bt + FRAME_FACTOR * (p + 1) / 2) / (FRAME_FACTOR * (p + 1));
    aft = (2 * q + 9) / 10;
    bef = q - 1 - aft;
    chk(32'(prescaler_field), p);
    chk(32'({segment_before_sample, segment_after_sample}), bef * 32 + aft);
    av(0, REG_TIMING, 0);
    chk(rd, (aft << 24) | (bef << 16) | (2 << 8) | p);
    av(0, REG_CHIP_ID, 0);
    chk(rd, 32'(CHIP_ID_RST));
    av(1, REG_CHIP_ID, 32'h0000BEEF);
    av(0, 5'h10, 0);
    chk(rd, 0);
    chk(32'(tx_data), 32'h00BEEFA5);
    chk(32'({tx_id, tx_dlc}), 32'h0E63);
    for (int i = 0; i < LOAD_BYTES; i++) begin
      if (i % 40 == 3) HOST.send_msg(11'h006, 0, 8'hFF);
      if (i == 70) HOST.send_msg(ACK_ID, 1, 0);
      HOST.send_msg(RX_ID, 0, 8'(i) ^ 8'h5A);
    end
    repeat (2) @(posedge sys_clk);
    chk(32'({exec_start, boot_loader_mode, exec_address}), 32'h3FA40);
    HOST.send_msg(RX_ID, 0, 8'h00);
    HOST.send_msg(ACK_ID, 1, 0);
    repeat (2) @(posedge sys_clk);
    chk(32'(nbytes), LOAD_BYTES);
    chk(32'(n_ack), 1);
    fetch_scan(1'b1);
  endtask
  // Watch the RAM port and count acknowledge requests
  always @(posedge sys_clk) begin
    if (rst === 1'b0 && ram_we === 1'b1) begin
      chk(32'(ram_addr), 32'(RAM_FIRST) + nbytes);
      chk(32'(ram_wdata), 32'(nbytes[7:0] ^ 8'h5A));
      nbytes++;
    end
    if (rst === 1'b0 && tx_request === 1'b1) n_ack++;
  end
  initial begin
    boot(1'b1);
    HOST.zero_frame(20);
    chk(32'({boot_loader_mode, can_transmit_oe}), 0);
    fetch_scan(1'b0);
    boot(1'b0);
    uart_receive_line <= 1'b0;
    repeat (3) @(posedge sys_clk);
    uart_receive_line <= 1'b1;
    chk(32'({uart_boot_selected, boot_loader_mode, can_transmit_oe}), 6);
    run(20);
    run(60);
    print_verdict();
  end
  initial begin
    #200000;
    fail_count++;
    print_verdict();
  end
endmodule // can_boot_loader_test
`default_nettype wire
